// >>> interrupt_latch_bank.sv
`timescale 1ns/10ps
module interrupt_latch_bank
	import standby_pkg::*;
#(
	parameter int WIDTH = INT_COUNT
)
(
	input  wire logic             clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] set_pulse,
	input  wire logic             load_en,
	input  wire logic [WIDTH-1:0] load_data,
	output logic      [WIDTH-1:0] latch
);

	logic [WIDTH-1:0] latch_reg;
	logic [WIDTH-1:0] latch_next;

	// Writing zero clears a latch; a new event in that cycle wins
	always_comb
	begin
		latch_next = latch_reg;
		if (load_en)
			latch_next = latch_reg & load_data;
		latch_next = latch_next | set_pulse;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			latch_reg <= WIDTH'(INT_LATCH_RESET);
		else
			latch_reg <= latch_next;
	end

	assign latch = latch_reg;

endmodule : interrupt_latch_bank

// >>> standby_mode_controller.sv
`timescale 1ns/10ps
// Behaviour
// - Peripheral standby halts CPU and watchdog; peripherals stay clocked.
// - Any standby freezes memory, registers, status word and port latches.
// - Resume address is entry instruction address plus two.
// - Writing one to the standby bit enters peripheral standby.
// - Leaving peripheral standby clears its bit and restores prior run mode.
// - Reset ends any standby and starts in high-speed single-clock run.
// - Master off: enabled interrupt wakes, no service, continue next instruction.
// - Master on: enabled interrupt wakes and is serviced first.
// - Pending watchdog interrupt blocks standby entry and gets serviced.
// - Clock-gated standby feeds only the time base timer.
// - Writing one to the halt bit enters clock-gated standby.
// - Leaving clock-gated standby clears halt bit, restores prior run mode.
// - Time base enabled at gated entry sets the time base latch.
// - Gated entry and exit ignore the time base enable.
// - Falling edge of chosen time base source ends gated standby.
// - With all three enables set, that wake also services time base.
// - Wake edge is asynchronous to the period, so sleep may be shorter.
// - Reset is raised when the oscillator feeding the main clock is off.
module standby_mode_controller
	import standby_pkg::*;
#(
	parameter int TB_SOURCES = 8
)
(
	input  wire logic                  clk,
	input  wire logic                  rstn,
	input  wire logic [7:0]            paddr,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [15:0]           instr_addr,
	input  wire logic [INT_COUNT-1:0]  int_sources,
	input  wire logic [TB_SOURCES-1:0] tb_sources,
	output gate_control_type           gate,
	output clock_control_type          clocks,
	output run_mode_type               run_mode,
	output logic      [15:0]           resume_pc,
	output logic                       irq_request,
	output logic      [INT_COUNT-1:0]  irq_latches,
	output logic                       osc_fault_reset
);

	function automatic logic addr_known(input logic [7:0] a);
		if (a == SYS_CONTROL_ADDR)
			return 1'b1;
		else if (a == INT_MASTER_ADDR)
			return 1'b1;
		else if (a == INT_ENABLE_ADDR)
			return 1'b1;
		else if (a == INT_LATCH_ADDR)
			return 1'b1;
		else if (a == TB_CONTROL_ADDR)
			return 1'b1;
		else if (a == STATUS_ADDR)
			return 1'b1;
		else if (a == RESUME_PC_ADDR)
			return 1'b1;
		else
			return 1'b0;
	endfunction : addr_known

	standby_state_type      state_reg;
	clock_control_type      clk_ctl_reg;
	clock_control_type      saved_clk_reg;
	logic                   master_en_reg;
	logic [INT_COUNT-1:0]   int_enable_reg;
	logic [7:0]             tb_control_reg;
	logic [15:0]            resume_pc_reg;
	logic [31:0]            prdata_reg;
	logic                   osc_fault_reg;
	logic [31:0]            rdata_next;
	logic [INT_COUNT-1:0]   latch;
	logic [INT_COUNT-1:0]   latch_set;
	logic                   wr_access;
	logic                   sys_write;
	logic                   wdt_pending;
	logic                   enter_periph;
	logic                   enter_gated;
	logic                   int_wake;
	logic                   tb_fall;
	logic                   wake;
	logic                   tb_enable;

	////////////////////////////////////////////////////////////////////////////
	// APB access and entry decode

	assign wr_access   = psel && penable && pwrite;
	assign pready      = psel && penable;
	assign pslverr     = psel && penable && !addr_known(paddr);
	assign sys_write   = wr_access && (paddr == SYS_CONTROL_ADDR) && (state_reg == ST_RUN);
	assign wdt_pending = latch[WDT_INT_BIT];
	assign tb_enable   = tb_control_reg[TB_ENABLE_BIT];

	// a write with both bits is refused
	assign enter_periph = sys_write && pwdata[STANDBY_BIT] && !pwdata[TG_HALT_BIT] && !wdt_pending;

	assign enter_gated = sys_write && pwdata[TG_HALT_BIT] && !pwdata[STANDBY_BIT] && !wdt_pending;

	////////////////////////////////////////////////////////////////////////////
	// Wake sources

	// any enabled latch wakes peripheral standby, master enable irrelevant
	assign int_wake = |(latch & int_enable_reg);

	time_base_edge #(
		.SOURCES (TB_SOURCES)
	) u_tb_edge (
		.clk     (clk),
		.rstn    (rstn),
		.sources (tb_sources),
		.select  (tb_control_reg[TB_SEL_WIDTH-1:0]),
		.fall    (tb_fall)
	);

	assign wake = ((state_reg == ST_PERIPH_STANDBY) && int_wake)
		|| ((state_reg == ST_CLOCK_GATED) && tb_fall);

	////////////////////////////////////////////////////////////////////////////
	// Mode state

	// reset returns to run with reset clocks
	always_ff @(posedge clk)
	begin
		if (!rstn)
			state_reg <= ST_RUN;
		else
		begin
			case (state_reg)
				ST_RUN:
				begin
					if (enter_periph)
						state_reg <= ST_PERIPH_STANDBY;
					else if (enter_gated)
						state_reg <= ST_CLOCK_GATED;
				end
				ST_PERIPH_STANDBY:
				begin
					if (int_wake)
						state_reg <= ST_RUN;
				end
				ST_CLOCK_GATED:
				begin
					if (tb_fall)
						state_reg <= ST_RUN;
				end
				default:
					state_reg <= ST_RUN;
			endcase
		end
	end

	// restore clock selection saved at entry
	always_ff @(posedge clk)
	begin
		if (!rstn)
			clk_ctl_reg <= CLOCK_RESET;
		else if (wake)
			clk_ctl_reg <= saved_clk_reg;
		else if (sys_write)
			clk_ctl_reg <= '{hf_osc_en: pwdata[HF_OSC_BIT], lf_osc_en: pwdata[LF_OSC_BIT],
				main_clock_select: pwdata[CLK_SELECT_BIT]};
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			saved_clk_reg <= CLOCK_RESET;
			resume_pc_reg <= 16'h0000;
		end
		else if (enter_periph || enter_gated)
		begin
			saved_clk_reg <= clk_ctl_reg;
			resume_pc_reg <= 16'(instr_addr + PC_STEP);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt registers

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			master_en_reg  <= 1'b0;
			int_enable_reg <= INT_ENABLE_RESET;
			tb_control_reg <= TB_CONTROL_RESET;
		end
		else if (wr_access)
		begin
			if (paddr == INT_MASTER_ADDR)
				master_en_reg <= pwdata[0];
			else if (paddr == INT_ENABLE_ADDR)
				int_enable_reg <= pwdata[INT_COUNT-1:0];
			else if (paddr == TB_CONTROL_ADDR)
				tb_control_reg <= pwdata[7:0];
		end
	end

	// time base latch set at gated entry
	always_comb
	begin
		latch_set = int_sources;
		if (enter_gated && tb_enable)
			latch_set[TB_INT_BIT] = 1'b1;
	end

	interrupt_latch_bank #(
		.WIDTH (INT_COUNT)
	) u_latches (
		.clk       (clk),
		.rstn      (rstn),
		.set_pulse (latch_set),
		.load_en   (wr_access && (paddr == INT_LATCH_ADDR)),
		.load_data (pwdata[INT_COUNT-1:0]),
		.latch     (latch)
	);

	// time base serviced via its latch
	assign irq_request = (master_en_reg && int_wake) || wdt_pending;
	assign irq_latches = latch;

	////////////////////////////////////////////////////////////////////////////
	// Clock gating and hold

	// CPU and watchdog halted in standby
	// only time base clocked when gated
	always_comb
	begin
		gate.cpu_halt         = (state_reg != ST_RUN);
		gate.watchdog_halt    = (state_reg != ST_RUN);
		gate.periph_clk_en    = (state_reg != ST_CLOCK_GATED);
		gate.time_base_clk_en = 1'b1;
		gate.hold_state       = (state_reg != ST_RUN);
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			osc_fault_reg <= 1'b0;
		else
			osc_fault_reg <= osc_fault(clk_ctl_reg);
	end

	assign clocks          = clk_ctl_reg;
	assign run_mode        = run_mode_of(clk_ctl_reg);
	assign resume_pc       = resume_pc_reg;
	assign osc_fault_reset = osc_fault_reg;

	////////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup phase so it comes from a flop

	always_comb
	begin
		rdata_next = 32'h0000_0000;
		if (paddr == SYS_CONTROL_ADDR)
		begin
			rdata_next[HF_OSC_BIT]     = clk_ctl_reg.hf_osc_en;
			rdata_next[LF_OSC_BIT]     = clk_ctl_reg.lf_osc_en;
			rdata_next[CLK_SELECT_BIT] = clk_ctl_reg.main_clock_select;
			rdata_next[STANDBY_BIT]    = (state_reg == ST_PERIPH_STANDBY);
			rdata_next[TG_HALT_BIT]    = (state_reg == ST_CLOCK_GATED);
		end
		else if (paddr == INT_MASTER_ADDR)
			rdata_next[0] = master_en_reg;
		else if (paddr == INT_ENABLE_ADDR)
			rdata_next[INT_COUNT-1:0] = int_enable_reg;
		else if (paddr == INT_LATCH_ADDR)
			rdata_next[INT_COUNT-1:0] = latch;
		else if (paddr == TB_CONTROL_ADDR)
			rdata_next[7:0] = tb_control_reg;
		else if (paddr == STATUS_ADDR)
			rdata_next[4:0] = {osc_fault_reg, state_reg, run_mode_of(clk_ctl_reg)};
		else if (paddr == RESUME_PC_ADDR)
			rdata_next[15:0] = resume_pc_reg;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			prdata_reg <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_reg <= rdata_next;
	end

	assign prdata = prdata_reg;

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	halt_in_standby_a: assert property (
		state_reg == ST_PERIPH_STANDBY |-> gate.cpu_halt && gate.watchdog_halt && gate.periph_clk_en)
		else $error("peripheral standby gating wrong");
	hold_in_standby_a: assert property (
		state_reg != ST_RUN |-> gate.hold_state)
		else $error("state not held in standby");
	resume_pc_a: assert property (
		enter_periph || enter_gated |=> resume_pc == 16'($past(instr_addr) + PC_STEP) ##1 $stable(resume_pc))
		else $error("resume address wrong");
	standby_entry_a: assert property (
		enter_periph |=> state_reg == ST_PERIPH_STANDBY && gate.cpu_halt)
		else $error("standby not entered");
	wake_restore_a: assert property (
		wake |=> state_reg == ST_RUN && clocks == $past(saved_clk_reg))
		else $error("wake did not restore run mode");
	reset_mode_a: assert property (
		disable iff (1'b0) !rstn |=> state_reg == ST_RUN && run_mode == HIGH_SPEED_SINGLE_CLOCK_RUN)
		else $error("reset did not give high-speed run");
	int_wake_a: assert property (
		state_reg == ST_PERIPH_STANDBY && int_wake |=> state_reg == ST_RUN && !gate.cpu_halt)
		else $error("enabled interrupt did not wake");
	int_service_a: assert property (
		state_reg == ST_PERIPH_STANDBY && master_en_reg && int_wake |-> irq_request)
		else $error("wake interrupt not requested");
	wdt_abort_a: assert property (
		sys_write && wdt_pending |=> state_reg == ST_RUN && irq_request)
		else $error("standby entered with watchdog pending");
	gated_clocks_a: assert property (
		state_reg == ST_CLOCK_GATED |-> !gate.periph_clk_en && gate.time_base_clk_en)
		else $error("clock-gated standby gating wrong");
	gated_entry_a: assert property (
		enter_gated |=> state_reg == ST_CLOCK_GATED && !gate.periph_clk_en && gate.hold_state)
		else $error("clock-gated standby not entered");
	tb_latch_a: assert property (
		enter_gated && tb_enable |=> latch[TB_INT_BIT])
		else $error("time base latch not set at entry");
	gated_wake_a: assert property (
		state_reg == ST_CLOCK_GATED && tb_fall |=> state_reg == ST_RUN)
		else $error("time base edge did not wake");
	osc_fault_a: assert property (
		osc_fault(clk_ctl_reg) |=> osc_fault_reset)
		else $error("oscillator fault reset missing");
	cover_periph_cycle: cover property (enter_periph ##[1:50] state_reg == ST_RUN);
	cover_gated_cycle: cover property (enter_gated ##[1:50] state_reg == ST_RUN);
	cover_wdt_abort: cover property (sys_write && wdt_pending);

endmodule : standby_mode_controller

// >>> standby_partner.sv
`timescale 1ns/10ps
// Far side: interrupt sources and time base source clocks
module standby_partner
	import standby_pkg::*;
(
	input  wire logic                 clk,
	input  wire logic                 rstn,
	input  wire logic [INT_COUNT-1:0] pulse_req,
	input  wire logic                 tb_run,
	output logic      [INT_COUNT-1:0] int_sources,
	output logic      [7:0]           tb_sources
);
	logic [7:0] div_reg;

	// Interrupt set requests last exactly one cycle
	always_ff @(posedge clk)
	begin
		if (!rstn)
			int_sources <= '0;
		else
			int_sources <= pulse_req;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end

	// peripherals held idle
	// Idle sources sit high while tb_run is low; the divider keeps counting, so release can give an immediate falling edge
	assign tb_sources = tb_run ? div_reg : 8'hFF;
endmodule : standby_partner

// >>> standby_pkg.sv
package standby_pkg;

	localparam logic [7:0] SYS_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] INT_MASTER_ADDR  = 8'h04;
	localparam logic [7:0] INT_ENABLE_ADDR  = 8'h08;
	localparam logic [7:0] INT_LATCH_ADDR   = 8'h0C;
	localparam logic [7:0] TB_CONTROL_ADDR  = 8'h10;
	localparam logic [7:0] STATUS_ADDR      = 8'h14;
	localparam logic [7:0] RESUME_PC_ADDR   = 8'h18;

	localparam int HF_OSC_BIT     = 7;
	localparam int LF_OSC_BIT     = 6;
	localparam int CLK_SELECT_BIT = 5;
	localparam int STANDBY_BIT    = 4;
	localparam int TG_HALT_BIT    = 2;
	localparam int WDT_INT_BIT    = 0;
	localparam int TB_INT_BIT     = 6;
	localparam int TB_ENABLE_BIT  = 7;
	localparam int INT_COUNT      = 8;
	localparam int TB_SEL_WIDTH   = 3;

	localparam logic [15:0] PC_STEP          = 16'h0002;
	localparam logic [7:0]  INT_ENABLE_RESET = 8'h00;
	localparam logic [7:0]  INT_LATCH_RESET  = 8'h00;
	localparam logic [7:0]  TB_CONTROL_RESET = 8'h00;

	typedef struct packed {
		logic hf_osc_en;
		logic lf_osc_en;
		logic main_clock_select;
	} clock_control_type;

	localparam clock_control_type CLOCK_RESET = '{hf_osc_en: 1'b1, lf_osc_en: 1'b0, main_clock_select: 1'b0};

	typedef struct packed {
		logic cpu_halt;
		logic watchdog_halt;
		logic periph_clk_en;
		logic time_base_clk_en;
		logic hold_state;
	} gate_control_type;

	typedef enum logic [1:0] {
		ST_RUN            = 2'b00,
		ST_PERIPH_STANDBY = 2'b01,
		ST_CLOCK_GATED    = 2'b10
	} standby_state_type;

	typedef enum logic [1:0] {
		HIGH_SPEED_SINGLE_CLOCK_RUN = 2'b00,
		HIGH_SPEED_DUAL_CLOCK_RUN   = 2'b01,
		LOW_SPEED_TRANSITION_RUN    = 2'b10,
		LOW_SPEED_RUN               = 2'b11
	} run_mode_type;

	function automatic run_mode_type run_mode_of(input clock_control_type c);
		if (!c.main_clock_select)
			return c.lf_osc_en ? HIGH_SPEED_DUAL_CLOCK_RUN : HIGH_SPEED_SINGLE_CLOCK_RUN;
		else
			return c.hf_osc_en ? LOW_SPEED_TRANSITION_RUN : LOW_SPEED_RUN;
	endfunction : run_mode_of

	function automatic logic osc_fault(input clock_control_type c);
		return (!c.hf_osc_en && !c.lf_osc_en) || (!c.hf_osc_en && !c.main_clock_select)
			|| (!c.lf_osc_en && c.main_clock_select);
	endfunction : osc_fault

endpackage : standby_pkg

// >>> test_standby_mode_controller.sv
`timescale 1ns/10ps
module test_standby_mode_controller
	import standby_pkg::*;
;
	logic                 clk, rstn, psel, penable, pwrite, pready, pslverr, rerr;
	logic                 irq_request, osc_fault_reset, tb_run;
	logic [7:0]           paddr, tb_sources;
	logic [31:0]          pwdata, prdata, rdata;
	logic [15:0]          instr_addr, resume_pc;
	logic [INT_COUNT-1:0] int_sources, irq_latches, pulse_req;
	gate_control_type     gate;
	clock_control_type    clocks;
	run_mode_type         run_mode;
	integer               seed = 32'h0888d734;
	int                   failures = 0;
	int                   n_checks = 0;
	int                   k;

	standby_mode_controller #(.TB_SOURCES(8)) i_standby_mode_controller (.clk(clk), .rstn(rstn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_addr(instr_addr),
		.int_sources(int_sources), .tb_sources(tb_sources), .gate(gate), .clocks(clocks),
		.run_mode(run_mode), .resume_pc(resume_pc), .irq_request(irq_request),
		.irq_latches(irq_latches), .osc_fault_reset(osc_fault_reset));

	standby_partner i_standby_partner (.clk(clk), .rstn(rstn), .pulse_req(pulse_req),
		.tb_run(tb_run), .int_sources(int_sources), .tb_sources(tb_sources));

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask : chk

	task conclude;
		if (failures == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : conclude

	// Run mode named by a control byte: clock select picks the family, the other oscillator the variant
	function automatic run_mode_type exp_mode(input logic [7:0] ctl);
		if (!ctl[CLK_SELECT_BIT])
			return ctl[LF_OSC_BIT] ? HIGH_SPEED_DUAL_CLOCK_RUN : HIGH_SPEED_SINGLE_CLOCK_RUN;
		else
			return ctl[HF_OSC_BIT] ? LOW_SPEED_TRANSITION_RUN : LOW_SPEED_RUN;
	endfunction : exp_mode

	// Resume address wraps within the 16-bit program space
	function automatic logic [15:0] exp_resume(input logic [15:0] a);
		return 16'(a + PC_STEP);
	endfunction : exp_resume

	// Holds the whole request until pready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		rdata = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk(n < 16, 1, "no pready");
		@(negedge clk);
	endtask : apb

	task pulse(input int b);
		@(posedge clk);
		pulse_req <= 8'h01 << b;
		@(posedge clk);
		pulse_req <= '0;
	endtask : pulse

	task wake_wait(input int lim);
		int n;
		n = 0;
		while (gate.hold_state !== 1'b0 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		chk(n < lim, 1, "no wake");
	endtask : wake_wait

	////////////////////////////////////////////////////////////
	initial
	begin
		#200000;
		failures++;
		conclude();
	end

	initial
	begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		instr_addr = 16'h0000;
		pulse_req = '0;
		tb_run = 1'b0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk(run_mode, HIGH_SPEED_SINGLE_CLOCK_RUN, "reset mode");
		chk(gate, 5'b00110, "reset gate");
		apb(1'b0, SYS_CONTROL_ADDR, 32'h0);
		chk(rdata, 32'h80, "reset control");
		chk(rerr, 1'b0, "mapped error");
		apb(1'b0, 8'h20, 32'h0);
		chk(rerr, 1'b1, "unmapped error");
		chk(rdata, 32'h0, "unmapped data");
		apb(1'b1, SYS_CONTROL_ADDR, 32'hC0);
		chk(run_mode, exp_mode(8'hC0), "dual");
		apb(1'b1, SYS_CONTROL_ADDR, 32'hE0);
		chk(run_mode, exp_mode(8'hE0), "transition");
		apb(1'b1, SYS_CONTROL_ADDR, 32'h60);
		chk(run_mode, exp_mode(8'h60), "low speed");
		chk(osc_fault_reset, 0, "false fault");
		apb(1'b1, SYS_CONTROL_ADDR, 32'h20);
		@(negedge clk);
		chk(osc_fault_reset, 1, "fault missed");
		apb(1'b1, SYS_CONTROL_ADDR, 32'hC0);
		@(negedge clk);
		chk(osc_fault_reset, 0, "fault stuck");
		for (int i = 0; i < 4; i++)
		begin
			k = 1 + ($unsigned($random(seed)) % 7);
			@(posedge clk);
			instr_addr <= 16'($random(seed));
			apb(1'b1, INT_MASTER_ADDR, 32'h0);
			apb(1'b1, INT_ENABLE_ADDR, 32'h1 << k);
			if (i[0])
				apb(1'b1, INT_MASTER_ADDR, 32'h1);
			apb(1'b1, SYS_CONTROL_ADDR, 32'hD0);
			chk({gate.cpu_halt, gate.watchdog_halt, gate.periph_clk_en}, 3'b111, "idle gate");
			chk(gate.hold_state, 1, "no hold");
			chk(resume_pc, exp_resume(instr_addr), "resume pc");
			apb(1'b1, SYS_CONTROL_ADDR, 32'h80);
			chk(clocks, 3'b110, "clocks moved");
			pulse(k);
			wake_wait(10);
			chk(run_mode, exp_mode(8'hC0), "mode lost");
			apb(1'b0, SYS_CONTROL_ADDR, 32'h0);
			chk(rdata, 32'hC0, "standby bit");
			chk(irq_request, i[0], "service");
			apb(1'b1, INT_LATCH_ADDR, 32'h0);
			chk(irq_latches, 8'h00, "latch clear");
		end
		apb(1'b1, INT_MASTER_ADDR, 32'h0);
		for (int f = 0; f < 2; f++)
		begin
			pulse(WDT_INT_BIT);
			apb(1'b1, SYS_CONTROL_ADDR, f ? 32'hC4 : 32'hD0);
			chk({gate.hold_state, irq_request}, 2'b01, "watchdog");
			apb(1'b1, INT_LATCH_ADDR, 32'h0);
		end
		// Both request bits in one write must not enter either mode
		apb(1'b1, SYS_CONTROL_ADDR, 32'hD4);
		chk(gate.hold_state, 0, "double request");
		for (int i = 0; i < 3; i++)
		begin
			k = $unsigned($random(seed)) % 8;
			apb(1'b1, INT_MASTER_ADDR, i == 2);
			apb(1'b1, INT_ENABLE_ADDR, (i == 2) ? 32'h40 : 32'h0);
			apb(1'b1, TB_CONTROL_ADDR, ((i != 1) ? 32'h80 : 32'h0) | k);
			apb(1'b1, SYS_CONTROL_ADDR, 32'hC4);
			chk({gate.periph_clk_en, gate.time_base_clk_en, gate.hold_state}, 3'b011, "gated");
			chk(irq_latches[TB_INT_BIT], i != 1, "tb latch");
			@(posedge clk);
			tb_run <= 1'b1;
			wake_wait(300);
			chk(run_mode, exp_mode(8'hC0), "gated mode");
			apb(1'b0, SYS_CONTROL_ADDR, 32'h0);
			chk(rdata, 32'hC0, "halt bit");
			chk(irq_request, i == 2, "tb service");
			@(posedge clk);
			tb_run <= 1'b0;
			apb(1'b1, INT_LATCH_ADDR, 32'h0);
		end
		apb(1'b1, SYS_CONTROL_ADDR, 32'hD0);
		chk(gate.hold_state, 1, "final standby");
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		@(negedge clk);
		chk({gate, run_mode, clocks}, {5'b00110, HIGH_SPEED_SINGLE_CLOCK_RUN, CLOCK_RESET}, "pin reset");
		conclude();
	end
endmodule : test_standby_mode_controller

// >>> time_base_edge.sv
`timescale 1ns/10ps
module time_base_edge
	import standby_pkg::*;
#(
	parameter int SOURCES = 8
)
(
	input  wire logic                    clk,
	input  wire logic                    rstn,
	input  wire logic [SOURCES-1:0]      sources,
	input  wire logic [TB_SEL_WIDTH-1:0] select,
	output logic                         fall
);

	logic level;
	logic prev_reg;

	assign level = sources[select];

	always_ff @(posedge clk)
	begin
		if (!rstn)
			prev_reg <= 1'b0;
		else
			prev_reg <= level;
	end

	// Edge seen at any phase of the source, so a sleep can be shorter than one period
	assign fall = prev_reg && !level;

endmodule : time_base_edge
